// ==== rtl/pts_timer.sv ====
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pts_timer
    import pts_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic ssp_shift_tick,
    output pts_timebase_t pwm_timebase,
    output logic pwm_update
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = {2'b00, idx, 2'b00};
    endfunction : byte_addr

    // Last prescaler count for a divide select; 1x both mean sixteen
    function automatic logic [3:0] presc_last(input logic [1:0] sel);
        if (sel == 2'b00) begin
            presc_last = PRESC_LAST_1;
        end else if (sel == 2'b01) begin
            presc_last = PRESC_LAST_4;
        end else begin
            presc_last = PRESC_LAST_16;
        end
    endfunction : presc_last

    // ****************************************************************
    // State
    // ****************************************************************
    logic [7:0] counter_reg;
    logic [7:0] limit_reg;
    pts_ctrl_t ctrl_reg;
    logic [1:0] instr_div_reg;
    logic [3:0] presc_reg;
    logic [3:0] post_reg;
    logic match_flag_reg;
    logic [7:0] flags_other_reg;
    logic [7:0] enables_reg;
    logic [7:0] interrupt_control_reg;
    logic pready_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic irq_reg;
    logic match_reg;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic access;
    logic done;
    logic wr_done;
    logic rd_done;
    logic hit;
    logic wr_counter;
    logic wr_ctrl;
    logic wr_limit;
    logic wr_flags;
    logic wr_enables;
    logic wr_interrupt_control;
    logic rd_flags;
    logic [7:0] wbyte;
    logic [7:0] rd_value;

    // Access phase waits one cycle so read data comes from a flip-flop
    assign access = psel && penable;
    assign done = access && pready_reg;
    assign wr_done = done && pwrite && pstrb[0];
    assign rd_done = done && !pwrite;
    assign wbyte = pwdata[7:0];

    // Address decode and read multiplexer
    always_comb begin
        hit = 1'b1;
        rd_value = RST_ZERO;
        if (paddr == byte_addr(IDX_INTERRUPT_CONTROL)) begin
            rd_value = interrupt_control_reg;
        end else if (paddr == byte_addr(IDX_PERIPHERAL_FLAGS_ONE)) begin
            rd_value = flags_other_reg;
            rd_value[BIT_MATCH_FLAG] = match_flag_reg;
        end else if (paddr == byte_addr(IDX_PERIOD_COUNTER)) begin
            rd_value = counter_reg;
        end else if (paddr == byte_addr(IDX_TIMER_CONTROL)) begin
            rd_value = {1'b0, ctrl_reg[6:0]};
        end else if (paddr == byte_addr(IDX_PERIPHERAL_ENABLES_ONE)) begin
            rd_value = enables_reg;
        end else if (paddr == byte_addr(IDX_PERIOD_LIMIT)) begin
            rd_value = limit_reg;
        end else begin
            hit = 1'b0;
        end
    end

    assign wr_interrupt_control = wr_done && (paddr == byte_addr(IDX_INTERRUPT_CONTROL));
    assign wr_flags = wr_done && (paddr == byte_addr(IDX_PERIPHERAL_FLAGS_ONE));
    assign wr_counter = wr_done && (paddr == byte_addr(IDX_PERIOD_COUNTER));
    assign wr_ctrl = wr_done && (paddr == byte_addr(IDX_TIMER_CONTROL));
    assign wr_enables = wr_done && (paddr == byte_addr(IDX_PERIPHERAL_ENABLES_ONE));
    assign wr_limit = wr_done && (paddr == byte_addr(IDX_PERIOD_LIMIT));
    assign rd_flags = rd_done && (paddr == byte_addr(IDX_PERIPHERAL_FLAGS_ONE));

    // ****************************************************************
    // APB slave handshake
    // ****************************************************************

    // One wait state; pready drops the cycle after completion
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pready_reg <= 1'b0;
            prdata_reg <= '0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready_reg <= access && !pready_reg;
            if (access && !pready_reg) begin
                prdata_reg <= pwrite ? '0 : {24'h00_0000, rd_value};
                pslverr <= !hit; // Unmapped address answers with an error
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    assign pready = pready_reg;
    assign prdata = prdata_reg;

    // ****************************************************************
    // Instruction clock and prescaler
    // ****************************************************************
    logic instr_tick;
    logic presc_tick;
    logic at_limit;
    logic scaler_clear;

    // Oscillator divided by four gives the instruction clock
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            instr_div_reg <= '0;
        end else if (clk_en) begin
            instr_div_reg <= instr_div_reg + 2'b01;
        end
    end

    assign instr_tick = (instr_div_reg == INSTR_DIV_LAST);
    // Counter write or control write empties both scaler counts
    assign scaler_clear = wr_counter || wr_ctrl;
    // Stopped timer never ticks, so the prescaler and count hold while off; the instruction divider runs on
    assign presc_tick = instr_tick && ctrl_reg.counter_run && !scaler_clear &&
        (presc_reg == presc_last(ctrl_reg.clock_divide_select));
    assign at_limit = (counter_reg == limit_reg);

    // Prescaler count; reset clears it as well
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            presc_reg <= '0;
        end else if (clk_en) begin
            if (scaler_clear) begin
                presc_reg <= '0;
            end else if (instr_tick && ctrl_reg.counter_run) begin
                if (presc_reg >= presc_last(ctrl_reg.clock_divide_select)) begin
                    presc_reg <= '0;
                end else begin
                    presc_reg <= presc_reg + 4'h1;
                end
            end
        end
    end

    // ****************************************************************
    // Period counter
    // ****************************************************************

    // Software write wins over a tick in the same cycle; control writes keep the value
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            counter_reg <= RST_ZERO;
        end else if (clk_en) begin
            if (wr_counter) begin
                counter_reg <= wbyte;
            end else if (presc_tick) begin
                counter_reg <= at_limit ? RST_ZERO : counter_reg + 8'h01;
            end
        end
    end

    // Period limit register
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            limit_reg <= RST_PERIOD_LIMIT;
        end else if (clk_en && wr_limit) begin
            limit_reg <= wbyte;
        end
    end

    // Timer control; bit 7 is never stored
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrl_reg <= '0;
        end else if (clk_en && wr_ctrl) begin
            ctrl_reg <= {1'b0, wbyte[6:0] & CTRL_WRITE_MASK};
        end
    end

    // ****************************************************************
    // Match pulse and postscaler
    // ****************************************************************
    logic match_now;
    logic post_terminal;

    assign match_now = presc_tick && at_limit && !wr_counter;
    assign post_terminal = match_now && (post_reg == ctrl_reg.match_divide_select);

    // Postscaler counts matches from zero up to the select value n
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            post_reg <= '0;
        end else if (clk_en) begin
            if (scaler_clear) begin
                post_reg <= '0;
            end else if (post_terminal) begin
                post_reg <= '0;
            end else if (match_now) begin
                post_reg <= post_reg + 4'h1;
            end
        end
    end

    // Unscaled match pulse, registered, to the serial port and PWM units
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            match_reg <= 1'b0;
        end else if (clk_en) begin
            match_reg <= match_now;
        end
    end

    assign ssp_shift_tick = match_reg;

    // Time base shared by every PWM unit; both see the same count and match
    assign pwm_timebase.count = counter_reg;
    assign pwm_timebase.match = match_reg;

    // ****************************************************************
    // Flags, enables and interrupt
    // ****************************************************************

    // Match flag is sticky; set beats any clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            match_flag_reg <= 1'b0;
        end else if (clk_en) begin
            if (post_terminal) begin
                match_flag_reg <= 1'b1;
            end else if (rd_flags && prdata_reg[BIT_MATCH_FLAG]) begin
                // Clear only what the read returned, so a late event survives
                match_flag_reg <= 1'b0;
            end else if (wr_flags) begin
                match_flag_reg <= wbyte[BIT_MATCH_FLAG];
            end
        end
    end

    // Remaining flag bits belong to other peripherals; stored here, and a flags read clears the bits it returned
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            flags_other_reg <= RST_ZERO;
        end else if (clk_en) begin
            if (rd_flags) begin
                flags_other_reg <= flags_other_reg & ~prdata_reg[7:0];
            end else if (wr_flags) begin
                flags_other_reg <= wbyte & ~(8'h01 << BIT_MATCH_FLAG);
            end
        end
    end

    // Enable masks
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            enables_reg <= RST_ZERO;
            interrupt_control_reg <= RST_ZERO;
        end else if (clk_en) begin
            if (wr_enables) begin
                enables_reg <= wbyte;
            end
            if (wr_interrupt_control) begin
                interrupt_control_reg <= wbyte;
            end
        end
    end

    // Level interrupt from the match flag, gated by its enable and both interrupt control bits
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irq_reg <= 1'b0;
        end else if (clk_en) begin
            irq_reg <= match_flag_reg && enables_reg[BIT_MATCH_FLAG] &&
                interrupt_control_reg[BIT_PERIPHERAL_IRQ_ENABLE] && interrupt_control_reg[BIT_GLOBAL_IRQ_ENABLE];
        end
    end

    assign irq = irq_reg;

    // PWM duty reload follows the postscaled match, as the interrupt does
    logic pwm_update_reg;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pwm_update_reg <= 1'b0;
        end else if (clk_en) begin
            pwm_update_reg <= post_terminal;
        end
    end

    assign pwm_update = pwm_update_reg;

endmodule : pts_timer
`default_nettype wire

// ==== include/pts_pkg.sv ====
package pts_pkg;

    // ****************************************************************
    // Bus and register map
    // ****************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
    localparam logic [7:0] IDX_PERIPHERAL_FLAGS_ONE = 8'h0c;
    localparam logic [7:0] IDX_PERIOD_COUNTER = 8'h11;
    localparam logic [7:0] IDX_TIMER_CONTROL = 8'h12;
    localparam logic [7:0] IDX_PERIPHERAL_ENABLES_ONE = 8'h8c;
    localparam logic [7:0] IDX_PERIOD_LIMIT = 8'h92;

    // ****************************************************************
    // Reset values and field positions
    // ****************************************************************
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PERIOD_LIMIT = 8'hff;
    localparam int BIT_MATCH_FLAG = 1;
    localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
    localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
    localparam logic [6:0] CTRL_WRITE_MASK = 7'h7f;

    // ****************************************************************
    // Timing: the instruction clock is the oscillator divided by four
    // ****************************************************************
    localparam int OSC_PER_INSTR = 4;
    localparam logic [1:0] INSTR_DIV_LAST = 2'(OSC_PER_INSTR - 1);
    localparam logic [3:0] PRESC_LAST_1 = 4'h0;
    localparam logic [3:0] PRESC_LAST_4 = 4'h3;
    localparam logic [3:0] PRESC_LAST_16 = 4'hf;

    // Timer control register layout
    typedef struct packed {
        logic unused;
        logic [3:0] match_divide_select;
        logic counter_run;
        logic [1:0] clock_divide_select;
    } pts_ctrl_t;

    // Time-base outputs handed to the PWM units; the serial port takes the match alone as ssp_shift_tick
    typedef struct packed {
        logic [7:0] count;
        logic match;
    } pts_timebase_t;

endpackage : pts_pkg

// ==== verif/pts_timer_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
// ********
// Port checker
// ********
module pts_timer_properties
    import pts_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic ssp_shift_tick,
    input wire pts_timebase_t pwm_timebase,
    input wire logic pwm_update
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic wr;
    logic wr_d;
    logic [7:0] cnt;
    // Any completed write may legally move the count, so it is excused
    assign wr = psel && penable && pready && pwrite && clk_en;
    assign cnt = pwm_timebase.count;
    always_ff @(posedge sys_clk) begin
        wr_d <= wr;
    end
    property p_ready_wait; psel && penable && !pready && clk_en |=> pready; endproperty
    property p_ready_pulse; pready |-> psel && penable ##1 !pready; endproperty
    property p_err_ready; pslverr |-> pready && prdata == '0; endproperty
    property p_match_mirror;
        (pwm_timebase.match == ssp_shift_tick) and (ssp_shift_tick && clk_en |=> !ssp_shift_tick);
    endproperty
    // A low clock enable must freeze the count and the bus answer
    property p_freeze; !clk_en |=> $stable(cnt) && $stable(pready) && $stable(irq); endproperty
    property p_match_zero; ssp_shift_tick && !wr_d |-> cnt == 8'h00; endproperty
    property p_count_step;
        clk_en && !wr |=> $stable(cnt) || cnt == 8'($past(cnt) + 1) || cnt == 8'h00;
    endproperty
    property p_tick_gap; $changed(cnt) && !wr_d |=> ($stable(cnt) || wr_d)[*3]; endproperty
    property p_update_follows;
        pwm_update |-> ssp_shift_tick || $past(ssp_shift_tick) || $past(ssp_shift_tick, 2);
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("bus access left unanswered");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready outside access");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_match_mirror: assert property (p_match_mirror) else $error("match copies differ");
    a_match_zero: assert property (p_match_zero) else $error("match with nonzero count");
    a_count_step: assert property (p_count_step) else $error("count jumped");
    a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
    a_update_follows: assert property (p_update_follows) else $error("stray update");
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
    c_err: cover property (pslverr);
    c_match: cover property (ssp_shift_tick);
    c_update: cover property (pwm_update);
    c_irq: cover property ($rose(irq));
endmodule : pts_timer_properties
bind pts_timer pts_timer_properties u_pts_timer_properties (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .ssp_shift_tick(ssp_shift_tick), .pwm_timebase(pwm_timebase),
    .pwm_update(pwm_update));
`default_nettype wire

// ==== verif/pts_far_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ********
// Serial port and PWM consumers
// ********
module pts_far_model
    import pts_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic ssp_shift_tick,
    input wire pts_timebase_t pwm_timebase,
    input wire logic pwm_update,
    output int match_cnt,
    output int update_cnt
);
    // Count shift clocks and shared PWM reload instants
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            match_cnt <= 0;
            update_cnt <= 0;
        end else begin
            match_cnt <= match_cnt + int'(ssp_shift_tick);
            update_cnt <= update_cnt + int'(pwm_update);
        end
    end
endmodule : pts_far_model
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb
    import pts_pkg::*;
;
    // ********
    // Bench
    // ********
    logic sys_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'hf;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, irq, ssp_shift_tick, pwm_update, err;
    pts_timebase_t pwm_timebase;
    int match_cnt, update_cnt, error_cnt = 0, check_count = 0, seed = 39, m, n, p, u;
    logic [7:0] rd, v, lim;
    logic [7:0] map [6] = '{IDX_INTERRUPT_CONTROL, IDX_PERIPHERAL_FLAGS_ONE, IDX_PERIOD_COUNTER,
        IDX_TIMER_CONTROL, IDX_PERIPHERAL_ENABLES_ONE, IDX_PERIOD_LIMIT};
    logic [7:0] rst [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff};
    always #25 sys_clk = ~sys_clk;
    pts_timer u_pts_timer (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .ssp_shift_tick(ssp_shift_tick),
        .pwm_timebase(pwm_timebase), .pwm_update(pwm_update));
    pts_far_model u_pts_far_model (.sys_clk(sys_clk), .reset_n(reset_n), .ssp_shift_tick(ssp_shift_tick),
        .pwm_timebase(pwm_timebase), .pwm_update(pwm_update), .match_cnt(match_cnt), .update_cnt(update_cnt));
    function automatic int psdiv(input int ps);
        return ps == 0 ? 1 : ps == 1 ? 4 : 16;
    endfunction : psdiv
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tmo(input int k, input int lim_k);
        if (k >= lim_k) begin
            error_cnt++;
            $display("unexpected wait at %0t: seen %h expected %h", $time, k, lim_k);
            complete_run();
        end
    endtask : tmo
    // Setup, then access held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ADDR_W'({idx, 2'b00});
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge sys_clk); k++; end while (pready !== 1'b1 && k < 20);
        tmo(k, 20);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Edges until a pulse is seen, bounded
    task automatic wait_hi(ref logic s, output int k);
        k = 0;
        do begin @(posedge sys_clk); k++; end while (s !== 1'b1 && k < 3000);
        tmo(k, 3000);
    endtask : wait_hi
    initial begin
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (map[i]) begin apb(1'b0, map[i], 8'h00); chk(rd, rst[i]); end
        apb(1'b0, 8'h40, 8'h00);
        chk(err, 1'b1);
        $display("done: reset map");
        v = 8'($random(seed));
        apb(1'b1, IDX_PERIOD_LIMIT, v);
        pstrb <= 4'he;
        apb(1'b1, IDX_PERIOD_LIMIT, ~v);
        pstrb <= 4'hf;
        apb(1'b0, IDX_PERIOD_LIMIT, 8'h00);
        chk(rd, v);
        apb(1'b1, IDX_TIMER_CONTROL, 8'hfb);
        apb(1'b0, IDX_TIMER_CONTROL, 8'h00);
        chk(rd, 8'h7b);
        apb(1'b1, IDX_PERIOD_COUNTER, v);
        repeat (40) @(posedge sys_clk);
        apb(1'b0, IDX_PERIOD_COUNTER, 8'h00);
        chk(rd, v);
        apb(1'b1, IDX_TIMER_CONTROL, 8'h0b);
        apb(1'b0, IDX_PERIOD_COUNTER, 8'h00);
        chk(rd, v);
        $display("done: access");
        // Period per prescale code, limit kept small so the run stays short
        for (int ps = 0; ps < 4; ps++) begin
            lim = 8'(2 + ($random(seed) & 3));
            apb(1'b1, IDX_PERIOD_LIMIT, lim);
            apb(1'b1, IDX_PERIOD_COUNTER, 8'h00);
            apb(1'b1, IDX_TIMER_CONTROL, 8'(4 + ps));
            wait_hi(ssp_shift_tick, m);
            wait_hi(ssp_shift_tick, m);
            chk(m, 4 * psdiv(ps) * (lim + 1));
        end
        $display("done: prescale");
        apb(1'b1, IDX_PERIOD_LIMIT, 8'h01);
        for (int i = 0; i < 3; i++) begin
            p = i == 0 ? 0 : i == 1 ? 15 : $random(seed) & 15;
            apb(1'b1, IDX_TIMER_CONTROL, {1'b0, 4'(p), 3'b100});
            wait_hi(pwm_update, m);
            n = match_cnt;
            u = update_cnt;
            wait_hi(pwm_update, m);
            chk(match_cnt - n, p + 1);
            chk(update_cnt - u, 1);
            chk(m, 8 * (p + 1));
        end
        $display("done: postscale");
        apb(1'b1, IDX_TIMER_CONTROL, 8'h7c);
        apb(1'b1, IDX_PERIPHERAL_ENABLES_ONE, 8'h02);
        apb(1'b1, IDX_INTERRUPT_CONTROL, 8'hc0);
        apb(1'b0, IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
        wait_hi(pwm_update, m);
        repeat (3) @(posedge sys_clk);
        chk(irq, 1'b1);
        apb(1'b0, IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
        chk(rd, 8'h02);
        repeat (3) @(posedge sys_clk);
        chk(irq, 1'b0);
        apb(1'b1, IDX_INTERRUPT_CONTROL, 8'h80);
        wait_hi(pwm_update, m);
        repeat (3) @(posedge sys_clk);
        chk(irq, 1'b0);
        apb(1'b0, IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
        chk(rd, 8'h02);
        $display("done: interrupt");
        apb(1'b1, IDX_PERIOD_LIMIT, 8'hff);
        apb(1'b1, IDX_TIMER_CONTROL, 8'h06);
        for (int i = 0; i < 2; i++) begin
            repeat (40) @(posedge sys_clk);
            apb(1'b1, i == 0 ? IDX_PERIOD_COUNTER : IDX_TIMER_CONTROL, i == 0 ? 8'h10 : 8'h06);
            // The write lands at the edge that ends the task; sample one edge later
            @(posedge sys_clk);
            v = pwm_timebase.count;
            if (i == 0) chk(v, 8'h10);
            m = 0;
            do begin @(posedge sys_clk); m++; end while (pwm_timebase.count === v && m < 200);
            chk(m > 55 && m < 70, 1'b1);
        end
        $display("done: scaler clear");
        // Clock enable low must hold the running count still
        clk_en <= 1'b0;
        @(posedge sys_clk);
        v = pwm_timebase.count;
        repeat (100) @(posedge sys_clk);
        chk(pwm_timebase.count, v);
        clk_en <= 1'b1;
        $display("done: freeze");
        complete_run();
    end
endmodule : tb
`default_nettype wire
